/* File: wp_compare.sv */
// shared constants and types, plus the masked comparator of one watchpoint unit
`timescale 1ns/1ps

package wp_pkg;
   // -------------------------------------------------------------
   // sizes
   // -------------------------------------------------------------
   localparam int UNIT_COUNT = 2;      // watchpoint units in the pair
   localparam int REG_AW     = 8;      // register port address width
   localparam int BUS_W      = 32;     // core address and data width
   localparam int CV_W       = 9;      // stored control value width
   localparam int CM_W       = 8;      // control mask width
   localparam int CB_W       = 10;     // combined control bus width
   localparam int CORE_CW    = 5;      // core control bits c[4:0]
   localparam int EXT_W      = 2;      // external debug condition inputs

   // -------------------------------------------------------------
   // control bus bit positions and stored-value fields
   // -------------------------------------------------------------
   localparam int C_EXT_BIT    = 5;    // external debug condition
   localparam int C_CHAIN_BIT  = 6;    // chain input (unit 0 only)
   localparam int C_RANGE_BIT  = 7;    // range input (unit 0 only)
   localparam int C_VALID_BIT  = 8;    // core cycle valid
   localparam int C_SPARE_BIT  = 9;    // not compared, held low
   localparam int CV_ENABLE_BIT = 8;   // trigger enable in stored control value
   localparam int CTRL_DISABLE_BIT = 0; // comparator output disable

   // -------------------------------------------------------------
   // register map
   // -------------------------------------------------------------
   localparam int              UNIT_SHIFT    = 5;            // unit stride is 0x20
   localparam logic [REG_AW-1:0] OFF_ADDR_VAL  = 8'h00;
   localparam logic [REG_AW-1:0] OFF_ADDR_MASK = 8'h04;
   localparam logic [REG_AW-1:0] OFF_DATA_VAL  = 8'h08;
   localparam logic [REG_AW-1:0] OFF_DATA_MASK = 8'h0C;
   localparam logic [REG_AW-1:0] OFF_CTRL_VAL  = 8'h10;
   localparam logic [REG_AW-1:0] OFF_CTRL_MASK = 8'h14;
   localparam logic [REG_AW-1:0] OFF_CONTROL   = 8'h40;
   localparam logic [REG_AW-1:0] OFF_STATUS    = 8'h44;
   localparam logic [REG_AW-1:0] OFF_INT_MASK  = 8'h48;
   localparam logic [BUS_W-1:0]  WORD_ZERO     = 32'h0000_0000;

   // -------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic [BUS_W-1:0] address_compare_value;
      logic [BUS_W-1:0] address_compare_mask;
      logic [BUS_W-1:0] data_compare_value;
      logic [BUS_W-1:0] data_compare_mask;
      logic [CV_W-1:0]  control_compare_value;
      logic [CM_W-1:0]  control_compare_mask;
   } wp_cfg_t;

   typedef struct packed {
      logic [BUS_W-1:0]   addr;
      logic [BUS_W-1:0]   data;
      logic [CORE_CW-1:0] ctrl;
   } core_bus_t;

   localparam wp_cfg_t CFG_RESET = '0;  // exact compare, trigger disabled
endpackage : wp_pkg

// masked equality of one unit: pure logic, no state
module wp_compare
   import wp_pkg::*;
(
   input  wire wp_cfg_t         cfg,      // stored values and masks
   input  wire core_bus_t       bus,      // core address, data, control
   input  wire logic [CB_W-1:0] ctrl,     // combined control bus
   output logic                 addr_hit, // address plus c[4:0] match
   output logic                 data_hit  // data plus c[7:5] match
);
   // -------------------------------------------------------------
   // comparison
   // -------------------------------------------------------------
   // a mask bit of one forces its position to match; a hit needs all ones
   assign addr_hit = &(({cfg.address_compare_value, cfg.control_compare_value[CORE_CW-1:0]}
                      ~^ {bus.addr, ctrl[CORE_CW-1:0]})
                      | {cfg.address_compare_mask, cfg.control_compare_mask[CORE_CW-1:0]});
   assign data_hit = &(({cfg.data_compare_value,
                         cfg.control_compare_value[C_RANGE_BIT:C_EXT_BIT]}
                      ~^ {bus.data, ctrl[C_RANGE_BIT:C_EXT_BIT]})
                      | {cfg.data_compare_mask,
                         cfg.control_compare_mask[C_RANGE_BIT:C_EXT_BIT]});
endmodule : wp_compare

/* File: watchpoint_pair.sv */
// pair of coupled debug watchpoint units with chain latch, range coupling and irq
`timescale 1ns/1ps

module watchpoint_pair
   import wp_pkg::*;
#(
   parameter int NUM_UNITS = UNIT_COUNT   // fixed pair; coupling assumes two
)
(
   input  wire logic                  CLOCK,                    // 125 MHz system clock
   input  wire logic                  NRST,                     // async reset, active low
   input  wire logic [REG_AW-1:0]     REG_ADDR,                 // register byte address
   input  wire logic [BUS_W-1:0]      REG_WDATA,                // register write data
   input  wire logic                  REG_WR,                   // write strobe
   input  wire logic                  REG_RD,                   // read strobe
   output logic      [BUS_W-1:0]      REG_RDATA,                // read data, cycle after strobe
   input  wire logic [BUS_W-1:0]      CORE_ADDR,                // core address bus
   input  wire logic [BUS_W-1:0]      CORE_DATA,                // core data bus
   input  wire logic [CORE_CW-1:0]    CORE_CTRL,                // core control bits
   input  wire logic                  CORE_VALID,               // core cycle valid
   input  wire logic [EXT_W-1:0]      EXTERNAL_DEBUG_CONDITION, // one per unit
   output logic      [NUM_UNITS-1:0]  BREAK_MATCH,              // per-unit breakpoint
   output logic      [NUM_UNITS-1:0]  RANGE_MATCH_OUT,          // per-unit range output
   output logic                       CHAIN_MATCH_OUT,          // unit 1 chain latch
   output logic                       IRQ                       // level interrupt
);

   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   wp_cfg_t                cfg_reg [NUM_UNITS];   // per-unit comparator setup
   logic [CB_W-1:0]        ctrl_bus [NUM_UNITS];  // combined control bus per unit
   core_bus_t              core_bus;              // packed core buses
   logic [EXT_W-1:0]       ext_reg;               // sampled external conditions
   logic [NUM_UNITS-1:0]   addr_hit;              // address comparator outputs
   logic [NUM_UNITS-1:0]   data_hit;              // data comparator outputs
   logic [NUM_UNITS-1:0]   range_next;            // both comparators agree
   logic [NUM_UNITS-1:0]   break_next;            // range plus enable plus valid, not disabled
   logic                   chain_reg;             // unit 1 chain latch
   logic                   disable_reg;           // global comparator disable
   logic [NUM_UNITS-1:0]   status_reg;            // sticky break events
   logic [NUM_UNITS-1:0]   status_next;           // next sticky value
   logic [NUM_UNITS-1:0]   int_mask_reg;          // interrupt enables
   logic [NUM_UNITS-1:0]   range_reg;             // registered range outputs
   logic [NUM_UNITS-1:0]   break_reg;             // registered break outputs
   logic [BUS_W-1:0]       rd_next;               // read mux result
   logic                   irq_reg;               // registered interrupt
   logic                   status_rd;             // status read this cycle

   // -------------------------------------------------------------
   // address decode
   // -------------------------------------------------------------
   // true when a matches register off of unit u
   function automatic logic unit_sel(input logic [REG_AW-1:0] a,
                                     input int                u,
                                     input logic [REG_AW-1:0] off);
      logic [REG_AW-1:0] base;
      base     = REG_AW'(u) << UNIT_SHIFT;
      unit_sel = (a == (base | off));
   endfunction : unit_sel

   assign core_bus  = '{addr: CORE_ADDR, data: CORE_DATA, ctrl: CORE_CTRL};
   assign status_rd = REG_RD && (REG_ADDR == OFF_STATUS);

   // -------------------------------------------------------------
   // external condition sampling
   // -------------------------------------------------------------
   // inputs are synchronous; one flop stage places them on the clock edge
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         ext_reg <= '0;
      end else begin
         ext_reg <= EXTERNAL_DEBUG_CONDITION;
      end
   end

   // -------------------------------------------------------------
   // per-unit registers and comparators
   // -------------------------------------------------------------
   generate
      for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
         // configuration writes; masks reset to exact compare
         always_ff @(posedge CLOCK or negedge NRST) begin
            if (!NRST) begin
               cfg_reg[u] <= CFG_RESET;
            end else if (REG_WR) begin
               if (unit_sel(REG_ADDR, u, OFF_ADDR_VAL)) begin
                  cfg_reg[u].address_compare_value <= REG_WDATA;
               end
               if (unit_sel(REG_ADDR, u, OFF_ADDR_MASK)) begin
                  // a contiguous low mask gives a power-of-two window
                  cfg_reg[u].address_compare_mask <= REG_WDATA;
               end
               if (unit_sel(REG_ADDR, u, OFF_DATA_VAL)) begin
                  cfg_reg[u].data_compare_value <= REG_WDATA;
               end
               if (unit_sel(REG_ADDR, u, OFF_DATA_MASK)) begin
                  cfg_reg[u].data_compare_mask <= REG_WDATA;
               end
               if (unit_sel(REG_ADDR, u, OFF_CTRL_VAL)) begin
                  cfg_reg[u].control_compare_value <= REG_WDATA[CV_W-1:0];
               end
               if (unit_sel(REG_ADDR, u, OFF_CTRL_MASK)) begin
                  cfg_reg[u].control_compare_mask <= REG_WDATA[CM_W-1:0];
               end
            end
         end

         // combined control bus: core bits, other unit, external condition
         if (u == 0) begin : g_ctrl0
            assign ctrl_bus[u][CORE_CW-1:0] = CORE_CTRL;
            assign ctrl_bus[u][C_EXT_BIT]   = ext_reg[u];
            assign ctrl_bus[u][C_CHAIN_BIT] = chain_reg;
            // same-cycle coupling so both windows are judged on one access
            assign ctrl_bus[u][C_RANGE_BIT] = range_next[1];
            assign ctrl_bus[u][C_VALID_BIT] = CORE_VALID;
            assign ctrl_bus[u][C_SPARE_BIT] = 1'b0;
         end else begin : g_ctrl1
            // unit 1 has no chain or range input; those bits stay low
            assign ctrl_bus[u][CORE_CW-1:0] = CORE_CTRL;
            assign ctrl_bus[u][C_EXT_BIT]   = ext_reg[u];
            assign ctrl_bus[u][C_CHAIN_BIT] = 1'b0;
            assign ctrl_bus[u][C_RANGE_BIT] = 1'b0;
            assign ctrl_bus[u][C_VALID_BIT] = CORE_VALID;
            assign ctrl_bus[u][C_SPARE_BIT] = 1'b0;
         end

         // masked comparison of this unit
         wp_compare u_cmp (
            .cfg      (cfg_reg[u]),
            .bus      (core_bus),
            .ctrl     (ctrl_bus[u]),
            .addr_hit (addr_hit[u]),
            .data_hit (data_hit[u])
         );

         // range needs both comparators at once, regardless of enable
         assign range_next[u] = addr_hit[u] & data_hit[u];
         // with range low expected, unit 0 fires only outside unit 1's window
         assign break_next[u] = range_next[u]
                              & cfg_reg[u].control_compare_value[CV_ENABLE_BIT]
                              & CORE_VALID
                              & ~disable_reg;
      end
   endgenerate

   // -------------------------------------------------------------
   // chain latch of unit 1
   // -------------------------------------------------------------
   // written only on an address hit, holding the data result until the next
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         chain_reg <= 1'b0;
      end else if (addr_hit[1]) begin
         chain_reg <= data_hit[1];
      end
   end

   // -------------------------------------------------------------
   // match outputs
   // -------------------------------------------------------------
   // the disable bit silences break and range outputs while software reprograms a unit
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         range_reg <= '0;
         break_reg <= '0;
      end else begin
         range_reg <= range_next & ~{NUM_UNITS{disable_reg}};
         break_reg <= break_next;
      end
   end

   // -------------------------------------------------------------
   // control and interrupt mask registers
   // -------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         disable_reg  <= 1'b0;
         int_mask_reg <= '0;
      end else if (REG_WR) begin
         if (REG_ADDR == OFF_CONTROL) begin
            disable_reg <= REG_WDATA[CTRL_DISABLE_BIT];
         end
         if (REG_ADDR == OFF_INT_MASK) begin
            int_mask_reg <= REG_WDATA[NUM_UNITS-1:0];
         end
      end
   end

   // -------------------------------------------------------------
   // sticky status, cleared by a read
   // -------------------------------------------------------------
   // a break in the cycle of the clearing read survives: set beats clear
   always_comb begin
      status_next = status_reg;
      if (status_rd) begin
         status_next = '0;
      end
      status_next = status_next | break_next;
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         status_reg <= '0;
      end else begin
         status_reg <= status_next;
      end
   end

   // interrupt is registered from status_next, so it changes on the same edge as status_reg
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(status_next & int_mask_reg);
      end
   end

   // -------------------------------------------------------------
   // read mux
   // -------------------------------------------------------------
   // unmapped addresses read zero; narrow fields sit in the low bits
   always_comb begin
      rd_next = WORD_ZERO;
      for (int u = 0; u < NUM_UNITS; u++) begin
         if (unit_sel(REG_ADDR, u, OFF_ADDR_VAL)) begin
            rd_next = cfg_reg[u].address_compare_value;
         end
         if (unit_sel(REG_ADDR, u, OFF_ADDR_MASK)) begin
            rd_next = cfg_reg[u].address_compare_mask;
         end
         if (unit_sel(REG_ADDR, u, OFF_DATA_VAL)) begin
            rd_next = cfg_reg[u].data_compare_value;
         end
         if (unit_sel(REG_ADDR, u, OFF_DATA_MASK)) begin
            rd_next = cfg_reg[u].data_compare_mask;
         end
         if (unit_sel(REG_ADDR, u, OFF_CTRL_VAL)) begin
            rd_next = BUS_W'(cfg_reg[u].control_compare_value);
         end
         if (unit_sel(REG_ADDR, u, OFF_CTRL_MASK)) begin
            rd_next = BUS_W'(cfg_reg[u].control_compare_mask);
         end
      end
      case (REG_ADDR)
         OFF_CONTROL: begin
            rd_next = BUS_W'(disable_reg);
         end
         OFF_STATUS: begin
            rd_next = BUS_W'(status_reg);
         end
         OFF_INT_MASK: begin
            rd_next = BUS_W'(int_mask_reg);
         end
         default: begin
            rd_next = rd_next;   // unit registers or zero
         end
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         REG_RDATA <= WORD_ZERO;
      end else if (REG_RD) begin
         REG_RDATA <= rd_next;
      end else begin
         REG_RDATA <= WORD_ZERO;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign BREAK_MATCH     = break_reg;
   assign RANGE_MATCH_OUT = range_reg;
   assign CHAIN_MATCH_OUT = chain_reg;
   assign IRQ             = irq_reg;

endmodule : watchpoint_pair

/* File: core_bus_model.sv */
// processor core bus model: one core cycle at a time, inverted value between
`timescale 1ns/1ps

module core_bus_model
   import wp_pkg::*;
(
   input  wire logic CLOCK,  // system clock
   output core_bus_t bus,    // core address, data, control
   output logic      valid   // core cycle valid
);
   // -------------------------------------------------------------
   // idle and cycle drive
   // -------------------------------------------------------------
   // all ones at start: high address bits never match a small range
   initial begin
      bus   = '1;
      valid = 1'b0;
   end

   // between cycles the bus shows the inverse, never a stale copy
   task automatic drive(input core_bus_t b, input logic v);
      bus   <= b;
      valid <= v;
      @(posedge CLOCK);
      bus   <= ~b;
      valid <= 1'b0;
   endtask : drive
endmodule : core_bus_model

/* File: watchpoint_pair_assertions.sv */
// concurrent checks of the watchpoint pair at its ports
`timescale 1ns/1ps

module watchpoint_pair_assertions
   import wp_pkg::*;
#(
   parameter int NUM_UNITS = UNIT_COUNT  // units in the pair
)
(
   input wire logic                 CLOCK,
   input wire logic                 NRST,
   input wire logic [REG_AW-1:0]    REG_ADDR,
   input wire logic [BUS_W-1:0]     REG_WDATA,
   input wire logic                 REG_WR,
   input wire logic                 REG_RD,
   input wire logic [BUS_W-1:0]     REG_RDATA,
   input wire logic [BUS_W-1:0]     CORE_ADDR,
   input wire logic [BUS_W-1:0]     CORE_DATA,
   input wire logic [CORE_CW-1:0]   CORE_CTRL,
   input wire logic                 CORE_VALID,
   input wire logic [EXT_W-1:0]     EXTERNAL_DEBUG_CONDITION,
   input wire logic [NUM_UNITS-1:0] BREAK_MATCH,
   input wire logic [NUM_UNITS-1:0] RANGE_MATCH_OUT,
   input wire logic                 CHAIN_MATCH_OUT,
   input wire logic                 IRQ
);
   // -------------------------------------------------------------
   // shadow of the compare registers, rebuilt from bus writes
   // -------------------------------------------------------------
   logic [BUS_W-1:0] sh [0:1][0:5];  // av, am, dv, dm, cv, cm per unit
   logic             dis_reg;        // comparator outputs disabled
   logic [EXT_W-1:0] ext_reg;        // sampled external conditions
   logic             a0, d0, a1, d1; // address and data hits

   // shadow follows writes at the same edge as the design
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         sh      <= '{default: '0};
         dis_reg <= 1'b0;
      end else if (REG_WR && REG_ADDR[7:6] == 2'h0 && REG_ADDR[4:2] < 3'h6) begin
         sh[REG_ADDR[5]][REG_ADDR[4:2]] <= REG_WDATA;
      end else if (REG_WR && REG_ADDR == OFF_CONTROL) begin
         dis_reg <= REG_WDATA[CTRL_DISABLE_BIT];
      end
   end

   // external conditions take effect one cycle late
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         ext_reg <= '0;
      end else begin
         ext_reg <= EXTERNAL_DEBUG_CONDITION;
      end
   end

   // unit 1 sees no chain or range input, unit 0 sees both
   assign a1 = &(({sh[1][0], sh[1][4][4:0]} ~^ {CORE_ADDR, CORE_CTRL}) | {sh[1][1], sh[1][5][4:0]});
   assign d1 = &(({sh[1][2], sh[1][4][7:5]} ~^ {CORE_DATA, 2'h0, ext_reg[1]})
               | {sh[1][3], sh[1][5][7:5]});
   assign a0 = &(({sh[0][0], sh[0][4][4:0]} ~^ {CORE_ADDR, CORE_CTRL}) | {sh[0][1], sh[0][5][4:0]});
   assign d0 = &(({sh[0][2], sh[0][4][7:5]} ~^ {CORE_DATA, a1 & d1, CHAIN_MATCH_OUT, ext_reg[0]})
               | {sh[0][3], sh[0][5][7:5]});

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!NRST);

   chk_chain_capture: assert property (a1 |=> CHAIN_MATCH_OUT == $past(d1))
      else $error("chain latch missed unit 1 data compare");
   chk_chain_hold: assert property (!a1 |=> $stable(CHAIN_MATCH_OUT))
      else $error("chain latch moved without unit 1 address hit");
   chk_range_one: assert property (1'b1 |=> RANGE_MATCH_OUT[1] == $past(a1 && d1 && !dis_reg))
      else $error("unit 1 range output wrong");
   chk_range_zero: assert property (1'b1 |=> RANGE_MATCH_OUT[0] == $past(a0 && d0 && !dis_reg))
      else $error("unit 0 range output wrong");
   chk_break_one: assert property (1'b1 |=> BREAK_MATCH[1] ==
      $past(a1 && d1 && sh[1][4][CV_ENABLE_BIT] && CORE_VALID && !dis_reg))
      else $error("unit 1 break wrong");
   chk_break_zero: assert property (1'b1 |=> BREAK_MATCH[0] ==
      $past(a0 && d0 && sh[0][4][CV_ENABLE_BIT] && CORE_VALID && !dis_reg))
      else $error("unit 0 break wrong");
   chk_rdata_idle: assert property (!REG_RD |=> REG_RDATA == WORD_ZERO)
      else $error("read data outside the read cycle");
   chk_irq_fall: assert property ($fell(IRQ) |->
      $past(REG_RD) || $past(REG_RD, 2) || $past(REG_WR) || $past(REG_WR, 2))
      else $error("interrupt dropped without register access");

   cov_chain_break: cover property (BREAK_MATCH[0] && CHAIN_MATCH_OUT);
   cov_range_one: cover property (RANGE_MATCH_OUT == 2'h2);
   cov_irq: cover property ($rose(IRQ));
endmodule : watchpoint_pair_assertions

/* File: watchpoint_chain_range_coupling_bench.sv */
// self-checking bench of the coupled watchpoint pair
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module watchpoint_chain_range_coupling_bench
   import wp_pkg::*;
();
   typedef struct packed {
      logic [31:0] addr;  // core address
      logic        valid; // core cycle valid
      logic [1:0]  brk;   // expected breaks
      logic [1:0]  rng;   // expected range outputs
   } row_t;

   logic             clock, nrst, reg_wr, reg_rd, chain, irq;
   logic [7:0]       reg_addr;
   logic [31:0]      reg_wdata, reg_rdata, q;
   logic [EXT_W-1:0] ext;
   logic [1:0]       brk, rng;
   core_bus_t        core;
   logic             core_valid;
   int               err_total, checked, cycles;
   // range pair: unit 1 covers 32 bytes, unit 0 covers 256
   row_t rows [6] = '{'{32'h0000_0010, 1'h1, 2'h0, 2'h2},
                      '{32'h0000_0080, 1'h1, 2'h1, 2'h1},
                      '{32'h0000_0100, 1'h1, 2'h0, 2'h0},
                      '{32'h0000_0080, 1'h0, 2'h0, 2'h1},
                      '{32'h0000_00FF, 1'h1, 2'h1, 2'h1},
                      '{32'h0000_001F, 1'h1, 2'h0, 2'h2}};

   watchpoint_pair u_watchpoint_pair (
      .CLOCK(clock), .NRST(nrst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .CORE_ADDR(core.addr), .CORE_DATA(core.data), .CORE_CTRL(core.ctrl),
      .CORE_VALID(core_valid), .EXTERNAL_DEBUG_CONDITION(ext), .BREAK_MATCH(brk),
      .RANGE_MATCH_OUT(rng), .CHAIN_MATCH_OUT(chain), .IRQ(irq));
   core_bus_model u_core_bus_model (.CLOCK(clock), .bus(core), .valid(core_valid));

   // -------------------------------------------------------------
   // clock, timeout, bus tasks
   // -------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // cut a hang short well past the expected run
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_total++;
         conclude();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic cfg(input int u, input logic [31:0] av, am, dv, dm, cv, cm);
      logic [7:0] b;
      b = u[7:0] << UNIT_SHIFT;
      wr(b + OFF_ADDR_VAL, av);
      wr(b + OFF_ADDR_MASK, am);
      wr(b + OFF_DATA_VAL, dv);
      wr(b + OFF_DATA_MASK, dm);
      wr(b + OFF_CTRL_VAL, cv);
      wr(b + OFF_CTRL_MASK, cm);
   endtask : cfg

   // one core cycle; outputs settle just after the next edge
   task automatic cyc(input logic [31:0] a, input logic [31:0] d, input logic v);
      @(posedge clock);
      u_core_bus_model.drive('{addr: a, data: d, ctrl: 5'h00}, v);
      #1;
   endtask : cyc

   task automatic conclude();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      {nrst, reg_wr, reg_rd, ext, reg_addr, reg_wdata} = '0;
      err_total = 0;
      checked = 0;
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      #1 `CHK(chain, 1'b0)
      rd(8'h04, q); `CHK(q, WORD_ZERO)
      rd(8'h30, q); `CHK(q, WORD_ZERO)
      cfg(1, 32'h0, 32'h0000_001F, 32'h0, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_00FF);
      cfg(0, 32'h0, 32'h0000_00FF, 32'h0, 32'hFFFF_FFFF, 32'h0000_0100, 32'h0000_007F);
      rd(8'h34, q); `CHK(q, 32'h0000_00FF)
      rd(8'h10, q); `CHK(q, 32'h0000_0100)
      foreach (rows[i]) begin
         cyc(rows[i].addr, 32'h0, rows[i].valid);
         `CHK(brk, rows[i].brk)
         `CHK(rng, rows[i].rng)
      end
      // disable bit silences breaks and ranges
      wr(OFF_CONTROL, 32'h0000_0001);
      cyc(32'h0000_0080, 32'h0, 1'b1);
      `CHK({brk, rng}, 4'h0)
      wr(OFF_CONTROL, WORD_ZERO);
      rd(OFF_STATUS, q); `CHK(q, 32'h0000_0001)
      // masked event is held but silent, unmask raises it
      cyc(32'h0000_0080, 32'h0, 1'b1);
      repeat (3) @(posedge clock);
      #1 `CHK(irq, 1'b0)
      wr(OFF_INT_MASK, 32'h0000_0001);
      repeat (3) @(posedge clock);
      #1 `CHK(irq, 1'b1)
      rd(OFF_STATUS, q); `CHK(q, 32'h0000_0001)
      repeat (2) @(posedge clock);
      #1 `CHK(irq, 1'b0)
      rd(OFF_STATUS, q); `CHK(q, WORD_ZERO)
      // chain: unit 1 watches 0x200 with data 0x55 and external bit
      cfg(1, 32'h0000_0200, 32'h0, 32'h0000_0055, 32'h0, 32'h0000_0020, 32'h0000_00DF);
      cfg(0, 32'h0000_0300, 32'h0, 32'h0, 32'hFFFF_FFFF, 32'h0000_0140, 32'h0000_00BF);
      // range rows left the chain set; an address hit with a data miss clears it
      cyc(32'h0000_0200, 32'h0000_0066, 1'b1); `CHK(chain, 1'b0)
      cyc(32'h0000_0300, 32'h0, 1'b1); `CHK(brk[0], 1'b0)
      cyc(32'h0000_0200, 32'h0000_0055, 1'b1); `CHK(chain, 1'b0)
      @(posedge clock);
      ext <= 2'h2;
      cyc(32'h0000_0200, 32'h0000_0066, 1'b1); `CHK(chain, 1'b0)
      cyc(32'h0000_0200, 32'h0000_0055, 1'b1); `CHK(chain, 1'b1)
      cyc(32'h0000_0300, 32'h0, 1'b1); `CHK(brk[0], 1'b1)
      `CHK(chain, 1'b1)
      cyc(32'h0000_0200, 32'h0000_0066, 1'b1); `CHK(chain, 1'b0)
      cyc(32'h0000_0200, 32'h0000_0055, 1'b1); `CHK(chain, 1'b1)
      // reset in mid-run drops the chain
      @(posedge clock);
      nrst <= 1'b0;
      #1 `CHK(chain, 1'b0)
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      // re-arm unit 0: a break now would mean a stale chain
      cfg(0, 32'h0000_0300, 32'h0, 32'h0, 32'hFFFF_FFFF, 32'h0000_0140, 32'h0000_00BF);
      cyc(32'h0000_0300, 32'h0, 1'b1); `CHK(brk, 2'h0)
      conclude();
   end
endmodule : watchpoint_chain_range_coupling_bench

bind watchpoint_pair watchpoint_pair_assertions #(.NUM_UNITS(NUM_UNITS)) u_chk (
   .CLOCK(CLOCK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CORE_ADDR(CORE_ADDR),
   .CORE_DATA(CORE_DATA), .CORE_CTRL(CORE_CTRL), .CORE_VALID(CORE_VALID),
   .EXTERNAL_DEBUG_CONDITION(EXTERNAL_DEBUG_CONDITION), .BREAK_MATCH(BREAK_MATCH),
   .RANGE_MATCH_OUT(RANGE_MATCH_OUT), .CHAIN_MATCH_OUT(CHAIN_MATCH_OUT), .IRQ(IRQ));
